// ### rtl/sprs_consts.vh
// Offsets, field positions and reset values of the serial/audio pin route select block
`ifndef SPRS_CONSTS_VH
`define SPRS_CONSTS_VH

// Register byte addresses
`define SPRS_CS_ROUTE_ADDR     12'h000
`define SPRS_AUD_ASSIGN_ADDR   12'h004
`define SPRS_ADDR_W            12

// Reset values
`define SPRS_CS_ROUTE_RESET    32'h0000_0000
`define SPRS_AUD_ASSIGN_RESET  32'h0000_0000

// Writable bit masks (reserved bits stay zero)
`define SPRS_CS6_MASK          32'h0000_00FF
`define SPRS_CS7_MASK          32'h0000_FF00
`define SPRS_AUD_MASK          32'h0FFF_0FFF

// Field codes
`define SPRS_CODE_NONE         2'h0
`define SPRS_CODE_ALT0         2'h1
`define SPRS_CODE_ALT1         2'h2

// Chip-select route fields, low bit of each
`define SPRS_CS0_LSB           0
`define SPRS_CS1_LSB           2
`define SPRS_CS2_LSB           4
`define SPRS_CS3_LSB           6

// Audio assignment fields, low bit of each
`define SPRS_A1_DOUT_LSB       26
`define SPRS_A1_DIN_LSB        24
`define SPRS_A1_WS_LSB         22
`define SPRS_A1_BCK_LSB        20
`define SPRS_A1_MCO_LSB        18
`define SPRS_A1_MCI_LSB        16
`define SPRS_A0_DOUT_LSB       10
`define SPRS_A0_DIN_LSB        8
`define SPRS_A0_WS_LSB         6
`define SPRS_A0_BCK_LSB        4
`define SPRS_A0_MCO_LSB        2
`define SPRS_A0_MCI_LSB        0

`endif

// ### rtl/sprs_pin_route.v
// APB pin route select for serial ch6 chip selects and two audio channels
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "sprs_consts.vh"

// What this block does
// - Bits 7:6 route chip-select 3: 00 none, 01 alt pin 0, 10 alt pin 1.
// - Bits 5:4 route chip-select 2: 00 none, 01 alt pin 0, 10 alt pin 1.
// - Bits 3:2 route chip-select 1: 00 none, 01 alt pin 0, 10 alt pin 1.
// - Bits 1:0 route chip-select 0: 00 none, 01 alt pin 0, 10 alt pin 1.
// - Reads return the stored field value with no side effect.
// - Registers keep contents through deep standby reset; other resets clear them.
// - Audio register bits 31:28 and 15:12 read zero; software writes zero.
// - Bits 27:26 route audio ch1 data out to its pin on code 01.
// - Bits 25:24 take audio ch1 data in from its pin on code 01.
// - Bits 23:22 connect audio ch1 word select pin on code 01.
// - Bits 21:20 connect audio ch1 bit clock pin on code 01.
// - Bits 19:18 drive audio ch1 master clock out pin on code 01.
// - Bits 17:16 take audio ch1 master clock in pin on code 01.
// - Bits 11:10 and 9:8 route audio ch0 data out and data in.
// - Bits 7:6 and 5:4 connect audio ch0 word select and bit clock.
// - Bits 3:2 and 1:0 route audio ch0 master clock out and in.
module sprs_pin_route (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        deep_standby_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Serial ch6 chip selects from the peripheral
  input  wire [3:0]  ch6_cs_in,
  output wire [3:0]  ch6_cs_alt0_out,
  output wire [3:0]  ch6_cs_alt0_oe,
  output wire [3:0]  ch6_cs_alt1_out,
  output wire [3:0]  ch6_cs_alt1_oe,
  // Audio peripheral side, index = channel
  input  wire [1:0]  aud_dout,
  input  wire [1:0]  aud_ws_o,
  input  wire [1:0]  aud_ws_oe,
  input  wire [1:0]  aud_bck_o,
  input  wire [1:0]  aud_bck_oe,
  input  wire [1:0]  aud_mclk_o,
  output wire [1:0]  aud_din,
  output wire [1:0]  aud_ws_i,
  output wire [1:0]  aud_bck_i,
  output wire [1:0]  aud_mclk_i,
  // Audio pins
  output wire [1:0]  pin_dout_o,
  output wire [1:0]  pin_dout_oe,
  input  wire [1:0]  pin_din_i,
  input  wire [1:0]  pin_ws_i,
  output wire [1:0]  pin_ws_o,
  output wire [1:0]  pin_ws_oe,
  input  wire [1:0]  pin_bck_i,
  output wire [1:0]  pin_bck_o,
  output wire [1:0]  pin_bck_oe,
  output wire [1:0]  pin_mco_o,
  output wire [1:0]  pin_mco_oe,
  input  wire [1:0]  pin_mci_i
);
  reg  [31:0] cs_route_q;
  reg  [31:0] cs_route_d;
  reg  [31:0] aud_assign_q;
  reg  [31:0] aud_assign_d;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  wire [31:0] strb_mask;
  wire        wr_en;
  wire        hit_cs;
  wire        hit_aud;
  wire [7:0]  pin_raw;
  wire [7:0]  pin_sync;

  // Named routing fields of the chip-select register
  wire [1:0]  ch6_cs3_route_sel;
  wire [1:0]  ch6_cs2_route_sel;
  wire [1:0]  ch6_cs1_route_sel;
  wire [1:0]  ch6_cs0_route_sel;
  wire [7:0]  ch7_cs_route_byte;
  wire [31:0] cs_route_rd;

  // Named routing fields of the audio assignment register
  wire [1:0]  aud1_data_out_route;
  wire [1:0]  aud1_data_in_route;
  wire [1:0]  aud1_word_sel_route;
  wire [1:0]  aud1_bit_clk_route;
  wire [1:0]  aud1_master_clk_out_route;
  wire [1:0]  aud1_master_clk_in_route;
  wire [1:0]  aud0_data_out_route;
  wire [1:0]  aud0_data_in_route;
  wire [1:0]  aud0_word_sel_route;
  wire [1:0]  aud0_bit_clk_route;
  wire [1:0]  aud0_master_clk_out_route;
  wire [1:0]  aud0_master_clk_in_route;
  wire [31:0] aud_assign_rd;

  assign ch6_cs3_route_sel = cs_route_q[`SPRS_CS3_LSB+1:`SPRS_CS3_LSB];
  assign ch6_cs2_route_sel = cs_route_q[`SPRS_CS2_LSB+1:`SPRS_CS2_LSB];
  assign ch6_cs1_route_sel = cs_route_q[`SPRS_CS1_LSB+1:`SPRS_CS1_LSB];
  assign ch6_cs0_route_sel = cs_route_q[`SPRS_CS0_LSB+1:`SPRS_CS0_LSB];
  assign ch7_cs_route_byte = cs_route_q[15:8];
  // Read view rebuilt from fields so unused upper bits always read zero
  assign cs_route_rd = {16'h0000, ch7_cs_route_byte, ch6_cs3_route_sel, ch6_cs2_route_sel,
                        ch6_cs1_route_sel, ch6_cs0_route_sel};

  assign aud1_data_out_route       = aud_assign_q[`SPRS_A1_DOUT_LSB+1:`SPRS_A1_DOUT_LSB];
  assign aud1_data_in_route        = aud_assign_q[`SPRS_A1_DIN_LSB+1:`SPRS_A1_DIN_LSB];
  assign aud1_word_sel_route       = aud_assign_q[`SPRS_A1_WS_LSB+1:`SPRS_A1_WS_LSB];
  assign aud1_bit_clk_route        = aud_assign_q[`SPRS_A1_BCK_LSB+1:`SPRS_A1_BCK_LSB];
  assign aud1_master_clk_out_route = aud_assign_q[`SPRS_A1_MCO_LSB+1:`SPRS_A1_MCO_LSB];
  assign aud1_master_clk_in_route  = aud_assign_q[`SPRS_A1_MCI_LSB+1:`SPRS_A1_MCI_LSB];
  assign aud0_data_out_route       = aud_assign_q[`SPRS_A0_DOUT_LSB+1:`SPRS_A0_DOUT_LSB];
  assign aud0_data_in_route        = aud_assign_q[`SPRS_A0_DIN_LSB+1:`SPRS_A0_DIN_LSB];
  assign aud0_word_sel_route       = aud_assign_q[`SPRS_A0_WS_LSB+1:`SPRS_A0_WS_LSB];
  assign aud0_bit_clk_route        = aud_assign_q[`SPRS_A0_BCK_LSB+1:`SPRS_A0_BCK_LSB];
  assign aud0_master_clk_out_route = aud_assign_q[`SPRS_A0_MCO_LSB+1:`SPRS_A0_MCO_LSB];
  assign aud0_master_clk_in_route  = aud_assign_q[`SPRS_A0_MCI_LSB+1:`SPRS_A0_MCI_LSB];
  // Reserved nibbles are inserted as constants
  assign aud_assign_rd = {4'h0, aud1_data_out_route, aud1_data_in_route, aud1_word_sel_route,
                          aud1_bit_clk_route, aud1_master_clk_out_route, aud1_master_clk_in_route,
                          4'h0, aud0_data_out_route, aud0_data_in_route, aud0_word_sel_route,
                          aud0_bit_clk_route, aud0_master_clk_out_route, aud0_master_clk_in_route};

  assign strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign hit_cs    = (paddr == `SPRS_CS_ROUTE_ADDR);
  assign hit_aud   = (paddr == `SPRS_AUD_ASSIGN_ADDR);
  assign wr_en     = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit_cs & ~hit_aud;

  // Register write path; ch7 fields are stored but route nothing here
  always @* begin
    cs_route_d   = cs_route_q;
    aud_assign_d = aud_assign_q;
    if (wr_en && hit_cs) begin
      cs_route_d = ((cs_route_q & ~strb_mask) | (pwdata & strb_mask))
                   & (`SPRS_CS6_MASK | `SPRS_CS7_MASK);
    end
    if (wr_en && hit_aud) begin
      aud_assign_d = ((aud_assign_q & ~strb_mask) | (pwdata & strb_mask)) & `SPRS_AUD_MASK;
    end
  end

  // Deep standby reset is deliberately not wired here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_route_q   <= `SPRS_CS_ROUTE_RESET;
      aud_assign_q <= `SPRS_AUD_ASSIGN_RESET;
      rdata_q      <= 32'h0000_0000;
    end else begin
      cs_route_q   <= cs_route_d;
      aud_assign_q <= aud_assign_d;
      rdata_q      <= rdata_d;
    end
  end

  // Read data is captured in setup so the access phase shows it from a flop
  always @* begin
    rdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit_cs) begin
        rdata_d = cs_route_rd;
      end else if (hit_aud) begin
        rdata_d = aud_assign_rd;
      end
    end else if (psel && penable) begin
      rdata_d = rdata_q;
    end
  end

  assign prdata = rdata_q;

  // Chip-select routing, one field per line
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cs
      wire [1:0] code;
      wire       sel0;
      wire       sel1;
      assign code = cs_route_q[2*gi+1:2*gi];
      assign sel0 = (code == `SPRS_CODE_ALT0);
      assign sel1 = (code == `SPRS_CODE_ALT1);
      assign ch6_cs_alt0_out[gi] = sel0 & ch6_cs_in[gi];
      assign ch6_cs_alt0_oe[gi]  = sel0;
      assign ch6_cs_alt1_out[gi] = sel1 & ch6_cs_in[gi];
      assign ch6_cs_alt1_oe[gi]  = sel1;
    end
  endgenerate

  // Pin inputs pass a two-flop synchroniser before any gating
  assign pin_raw = {pin_din_i, pin_ws_i, pin_bck_i, pin_mci_i};

  sprs_sync2 #(
    .W (8)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pin_raw),
    .q     (pin_sync)
  );

  // Audio routing, one block per channel; ch1 fields sit 16 bits above ch0
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_aud
      wire [1:0] c_dout;
      wire [1:0] c_din;
      wire [1:0] c_ws;
      wire [1:0] c_bck;
      wire [1:0] c_mco;
      wire [1:0] c_mci;
      wire       en_dout;
      wire       en_din;
      wire       en_ws;
      wire       en_bck;
      wire       en_mco;
      wire       en_mci;
      assign c_dout = aud_assign_q[`SPRS_A0_DOUT_LSB+16*gi+1:`SPRS_A0_DOUT_LSB+16*gi];
      assign c_din  = aud_assign_q[`SPRS_A0_DIN_LSB+16*gi+1:`SPRS_A0_DIN_LSB+16*gi];
      assign c_ws   = aud_assign_q[`SPRS_A0_WS_LSB+16*gi+1:`SPRS_A0_WS_LSB+16*gi];
      assign c_bck  = aud_assign_q[`SPRS_A0_BCK_LSB+16*gi+1:`SPRS_A0_BCK_LSB+16*gi];
      assign c_mco  = aud_assign_q[`SPRS_A0_MCO_LSB+16*gi+1:`SPRS_A0_MCO_LSB+16*gi];
      assign c_mci  = aud_assign_q[`SPRS_A0_MCI_LSB+16*gi+1:`SPRS_A0_MCI_LSB+16*gi];
      // Only code 01 connects; 10 and 11 act as 00
      assign en_dout = (c_dout == `SPRS_CODE_ALT0);
      assign en_din  = (c_din  == `SPRS_CODE_ALT0);
      assign en_ws   = (c_ws   == `SPRS_CODE_ALT0);
      assign en_bck  = (c_bck  == `SPRS_CODE_ALT0);
      assign en_mco  = (c_mco  == `SPRS_CODE_ALT0);
      assign en_mci  = (c_mci  == `SPRS_CODE_ALT0);
      assign pin_dout_o[gi]  = en_dout & aud_dout[gi];
      assign pin_dout_oe[gi] = en_dout;
      assign pin_ws_o[gi]    = en_ws & aud_ws_o[gi];
      assign pin_ws_oe[gi]   = en_ws & aud_ws_oe[gi];
      assign pin_bck_o[gi]   = en_bck & aud_bck_o[gi];
      assign pin_bck_oe[gi]  = en_bck & aud_bck_oe[gi];
      assign pin_mco_o[gi]   = en_mco & aud_mclk_o[gi];
      assign pin_mco_oe[gi]  = en_mco;
      assign aud_din[gi]     = en_din & pin_sync[6+gi];
      assign aud_ws_i[gi]    = en_ws  & pin_sync[4+gi];
      assign aud_bck_i[gi]   = en_bck & pin_sync[2+gi];
      assign aud_mclk_i[gi]  = en_mci & pin_sync[gi];
    end
  endgenerate

endmodule // sprs_pin_route

// ### rtl/sprs_sync2.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sprs_sync2 #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // sprs_sync2

// ### test/sprs_pin_route_asserts.sv
// Port-level checks of the pin route select block
`timescale 1ns/1ps
module sprs_pin_route_asserts (
  // Bus side
  input wire        pclk,
  input wire        presetn,
  input wire        deep_standby_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Routed signals
  input wire [3:0]  ch6_cs_in,
  input wire [3:0]  ch6_cs_alt0_out,
  input wire [3:0]  ch6_cs_alt0_oe,
  input wire [3:0]  ch6_cs_alt1_oe,
  input wire [1:0]  aud_din,
  input wire [1:0]  pin_din_i,
  input wire [1:0]  pin_mco_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cs_wr = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
  wire au_wr = psel && penable && pwrite && paddr == 12'h004 && pstrb[2];
  chk_cs_no_both: assert property ((ch6_cs_alt0_oe & ch6_cs_alt1_oe) == 4'h0)
    else $error("chip select on both pins");
  chk_cs_out_gate: assert property (ch6_cs_alt0_out == (ch6_cs_in & ch6_cs_alt0_oe))
    else $error("chip select pin level wrong");
  chk_cs0_write: assert property (cs_wr && pwdata[1:0] == 2'h1 |=> ch6_cs_alt0_oe[0])
    else $error("chip select 0 not routed after write");
  chk_cs3_alt: assert property (cs_wr && pwdata[7:6] == 2'h2 |=> ch6_cs_alt1_oe[3] && !ch6_cs_alt0_oe[3])
    else $error("chip select 3 alt pin wrong");
  chk_mco_bad_code: assert property (au_wr && pwdata[19:18] == 2'h2 |=> !pin_mco_oe[1])
    else $error("forbidden code drives pin");
  chk_din_sync: assert property ((aud_din & ~$past(pin_din_i, 2)) == 2'h0)
    else $error("data input not from pin");
  chk_err_where: assert property (pslverr |-> psel && penable && paddr != 12'h000 && paddr != 12'h004)
    else $error("error outside unmapped access");
  chk_aud_resv: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> (prdata & 32'hF000_F000) == 32'h0)
    else $error("reserved bits read nonzero");
  chk_standby_keep: assert property (deep_standby_rst && !psel |=> $stable(ch6_cs_alt0_oe) && $stable(pin_mco_oe))
    else $error("routing changed in deep standby");
  cover property (cs_wr);
  cover property (pslverr);
  cover property (deep_standby_rst ##1 deep_standby_rst);
endmodule // sprs_pin_route_asserts

// ### test/sprs_pin_route_test.sv
// Directed bench for the pin route select block
`timescale 1ns/1ps
`include "sprs_consts.vh"
module sprs_pin_route_test;
  localparam [11:0] CS = `SPRS_CS_ROUTE_ADDR;
  localparam [11:0] AU = `SPRS_AUD_ASSIGN_ADDR;
  reg         pclk = 1'h0, presetn = 1'h0, deep_standby_rst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0, r;
  reg  [3:0]  pstrb = 4'hF, ch6_cs_in = 4'hA;
  reg  [1:0]  aud_dout = 2'h3, aud_ws_o = 2'h3, aud_ws_oe = 2'h3, aud_bck_o = 2'h3, aud_bck_oe = 2'h3, m, w;
  reg  [1:0]  aud_mclk_o = 2'h3, pin_din_i = 2'h3, pin_ws_i = 2'h3, pin_bck_i = 2'h3, pin_mci_i = 2'h3;
  reg         e;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [3:0]  ch6_cs_alt0_out, ch6_cs_alt0_oe, ch6_cs_alt1_out, ch6_cs_alt1_oe;
  wire [1:0]  aud_din, aud_ws_i, aud_bck_i, aud_mclk_i, pin_dout_o, pin_dout_oe, pin_ws_o, pin_ws_oe;
  wire [1:0]  pin_bck_o, pin_bck_oe, pin_mco_o, pin_mco_oe;
  int         bad_count = 0, n_tests = 0, cyc = 0, c, n;

  sprs_pin_route dut (.*);

  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out;
    end
  end

  task automatic apb(input [11:0] a, input wr, input [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h got %h", nm, exp, got);
    end
  endtask
  task automatic rc(input [11:0] a, input [31:0] x);
    apb(a, 1'h0, 32'h0);
    chk("readback", x, r);
    chk("access cycles", 32'h1, n);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rc(CS, 32'h0);
    rc(AU, 32'h0);
    $display("test reset done");
    for (c = 0; c < 4; c++) begin
      ch6_cs_in <= ~ch6_cs_in;
      apb(CS, 1'h1, 32'hFFFF_0000 | {4{c[1:0]}});
      rc(CS, {4{c[1:0]}});
      chk("cs alt0", ch6_cs_in & {4{c == 1}}, ch6_cs_alt0_out);
      chk("cs alt1", ch6_cs_in & {4{c == 2}}, ch6_cs_alt1_out);
      chk("cs oe", {{4{c == 2}}, {4{c == 1}}}, {ch6_cs_alt1_oe, ch6_cs_alt0_oe});
    end
    apb(CS, 1'h1, 32'h93);
    rc(CS, 32'h93);
    chk("cs fields", 8'h84, {ch6_cs_alt1_oe, ch6_cs_alt0_oe});
    $display("test cs_route done");
    for (c = 0; c < 4; c++) begin
      {aud_dout, aud_ws_o, aud_ws_oe, aud_bck_o, aud_bck_oe, aud_mclk_o, pin_din_i, pin_ws_i, pin_bck_i, pin_mci_i} <= {10{c[1:0]}};
      m = (c == 1) ? 2'h3 : 2'h0;
      w = m & c[1:0];
      apb(AU, 1'h1, 32'hF000_F000 | {2{4'h0, {6{c[1:0]}}}});
      rc(AU, {2{4'h0, {6{c[1:0]}}}});
      chk("aud oe", {m, w, w, m, w, w, w, w}, {pin_dout_oe, pin_ws_oe, pin_bck_oe, pin_mco_oe, aud_din, aud_ws_i, aud_bck_i, aud_mclk_i});
      chk("aud out", {w, w, w, w}, {pin_dout_o & pin_dout_oe, pin_ws_o & pin_ws_oe, pin_bck_o & pin_bck_oe, pin_mco_o & pin_mco_oe});
    end
    apb(AU, 1'h1, 32'h0550_0000);
    rc(AU, 32'h0550_0000);
    chk("aud ch1", 10'h2A2, {pin_dout_oe, pin_ws_oe, pin_bck_oe, pin_mco_oe, aud_din});
    apb(AU, 1'h1, 32'h5);
    rc(AU, 32'h5);
    chk("aud mclk0", 6'h14, {pin_mco_oe, aud_mclk_i, pin_dout_oe});
    $display("test aud_route done");
    apb(12'h008, 1'h1, 32'hFFFF_FFFF);
    chk("slverr", 1'h1, e);
    rc(12'h008, 32'h0);
    rc(AU, 32'h5);
    deep_standby_rst <= 1'h1;
    repeat (4) @(posedge pclk);
    deep_standby_rst <= 1'h0;
    rc(AU, 32'h5);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rc(AU, 32'h0);
    $display("test keep_reset done");
    close_out;
  end
endmodule // sprs_pin_route_test

bind sprs_pin_route sprs_pin_route_asserts u_chk (.*);
